// ===== rtl/wap_cfg.svh
`ifndef WAP_CFG_SVH
`define WAP_CFG_SVH

// Register word offsets (byte addresses)
`define WAP_OFS_CTRL     8'h00
`define WAP_OFS_CMD      8'h04
`define WAP_OFS_COUNT    8'h08
`define WAP_OFS_RECLEN   8'h0C
`define WAP_OFS_ENVDIV   8'h10
`define WAP_OFS_DISPLEN  8'h14
`define WAP_OFS_STATUS   8'h18
`define WAP_OFS_ACQN     8'h1C
`define WAP_OFS_EXPK     8'h20

// Field positions
`define WAP_CMD_START    0
`define WAP_CMD_STOP     1
`define WAP_CNT_INF      17
`define WAP_ERR_MODE     0
`define WAP_ERR_COUNT    1
`define WAP_ERR_LEN      2
`define WAP_ERR_EXPK     3

// Reset values and the acquisition count limit
`define WAP_RST_RECLEN   27'h00186A0
`define WAP_RST_DISPLEN  27'h00186A0
`define WAP_RST_ENVDIV   16'h0002
`define WAP_RST_EXPK     4'h1
`define WAP_CNT_MAX      17'h10000

// Record length limits in points
`define WAP_LEN_MIN      27'd100000
`define WAP_LEN_5M       27'd5000000
`define WAP_LEN_10M      27'd10000000
`define WAP_LEN_25M      27'd25000000
`define WAP_LEN_50M      27'd50000000
`define WAP_LEN_100M     27'd100000000

`endif

// ===== rtl/wap_pkg.sv
package wap_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_ENVELOPE = 2'b01,
        MODE_AVERAGE  = 2'b10
    } wap_mode_t;

    typedef enum logic [2:0] {
        TRIG_AUTO     = 3'b000,
        TRIG_AUTO_LVL = 3'b001,
        TRIG_NORMAL   = 3'b010,
        TRIG_SINGLE   = 3'b011,
        TRIG_N_SINGLE = 3'b100,
        TRIG_ON_START = 3'b101
    } wap_trig_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } wap_fsm_t;

    // Memory option: 0 base, 1 first_memory_option, 2 second_memory_option
    typedef logic [1:0] wap_opt_t;

    typedef struct packed {
        wap_fsm_t        fsm;
        wap_mode_t       mode;
        wap_trig_t       trig;
        logic            roll;
        logic            action_on;
        wap_opt_t        opt;
        logic            cnt_inf;
        logic [16:0]     cnt;
        logic            pend;
        logic            pend_inf;
        logic [16:0]     pend_cnt;
        logic [3:0]      exp_k;
        logic [26:0]     reclen;
        logic [26:0]     disp_len;
        logic [15:0]     env_div;
        logic [15:0]     env_cnt;
        logic [26:0]     env_pt;
        logic [15:0]     env_max;
        logic [15:0]     env_min;
        logic [16:0]     acq_n;
        logic [31:0]     base;
        logic [3:0]      err;
        logic [31:0]     rdata;
        logic            mem_we;
        logic [31:0]     mem_addr;
        logic [31:0]     mem_wdata;
        logic            meas_valid;
        logic            pwr_valid;
        logic [15:0]     pwr_data;
    } wap_st_t;

endpackage : wap_pkg

// ===== rtl/wap_core.sv
`timescale 1ns/100ps
`include "wap_cfg.svh"

module wap_core (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_smp_valid,
    input  wire logic [15:0] i_smp_data,
    input  wire logic [26:0] i_smp_idx,
    input  wire logic        i_smp_last,
    input  wire logic        i_smp_pulse,
    input  wire logic [31:0] i_prev_data,
    output logic             o_mem_we,
    output logic      [31:0] o_mem_addr,
    output logic      [31:0] o_mem_wdata,
    output logic             o_meas_valid,
    output logic             o_meas_invalid,
    output logic             o_hist_ok,
    output logic             o_pwr_valid,
    output logic      [15:0] o_pwr_data,
    output logic             o_running
);
    import wap_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Single power of two test
    function automatic logic is_pow2(input logic [16:0] v);
        is_pow2 = (v != 17'h00000) && ((v & (v - 17'h00001)) == 17'h00000);
    endfunction : is_pow2
    // Log2 of a power of two
    function automatic logic [4:0] log2p(input logic [16:0] v);
        log2p = 5'h00;
        for (int i = 0; i < 17; i++) begin
            if (v[i]) begin
                log2p = 5'(i);
            end
        end
    endfunction : log2p
    // Largest record length for option and averaging
    function automatic logic [26:0] len_cap(input wap_opt_t o,
                                            input logic avg);
        case (o)
            2'h1:    len_cap = avg ? `WAP_LEN_10M : `WAP_LEN_50M;
            2'h2:    len_cap = avg ? `WAP_LEN_25M : `WAP_LEN_100M;
            default: len_cap = avg ? `WAP_LEN_5M  : `WAP_LEN_10M;
        endcase
    endfunction : len_cap
    // Whole record length check
    function automatic logic len_ok(input logic [26:0] len,
                                    input wap_opt_t o,
                                    input logic avg,
                                    input wap_trig_t t,
                                    input logic roll);
        logic cont;
        cont = !roll && (t == TRIG_AUTO || t == TRIG_AUTO_LVL ||
                         t == TRIG_NORMAL || t == TRIG_N_SINGLE);
        len_ok = (len >= `WAP_LEN_MIN) && (len <= len_cap(o, avg))
                 && !(cont && len >= len_cap(o, 1'b1));
    endfunction : len_ok
    // Acquisition count check for a mode
    function automatic logic cnt_ok(input logic [16:0] c, input logic avg);
        if (avg) begin
            cnt_ok = is_pow2(c) && c >= 17'h00002 && c <= `WAP_CNT_MAX;
        end else begin
            cnt_ok = c >= 17'h00001 && c <= `WAP_CNT_MAX;
        end
    endfunction : cnt_ok
    ////////////////////////////////////////////////////////////////////////
    // State
    wap_st_t st_r;
    wap_st_t st_nxt;
    logic              wr_hit;
    logic              avg;
    logic              single_like;
    logic              stop_now;
    logic              rec_end;
    logic signed [31:0] smp_ext;
    logic signed [31:0] prev;
    logic signed [31:0] acc;
    logic [15:0]       new_max;
    logic [15:0]       new_min;
    // Commonly used terms
    assign avg         = (st_r.mode == MODE_AVERAGE);
    assign single_like = (st_r.trig == TRIG_SINGLE) ||
                         (st_r.trig == TRIG_ON_START);
    assign wr_hit      = i_wr;
    assign rec_end     = (st_r.fsm == ST_RUN) && i_smp_valid && i_smp_last;
    assign smp_ext     = 32'(signed'(i_smp_data));
    assign prev        = signed'(i_prev_data);
    // Finite count reached on the last point of the final record
    assign stop_now    = rec_end && !st_r.cnt_inf &&
                         (st_r.acq_n + 17'h00001 == st_r.cnt);
    assign new_max     = (st_r.env_cnt == 16'h0000 ||
                          signed'(i_smp_data) > signed'(st_r.env_max)) ?
                         i_smp_data : st_r.env_max;
    assign new_min     = (st_r.env_cnt == 16'h0000 ||
                          signed'(i_smp_data) < signed'(st_r.env_min)) ?
                         i_smp_data : st_r.env_min;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt            = st_r;
        st_nxt.mem_we     = 1'b0;
        st_nxt.pwr_valid  = 1'b0;
        st_nxt.rdata      = 32'h00000000;
        acc               = 32'h00000000;
        // Register read, data stands in the following cycle
        if (i_rd) begin
            case (i_addr)
                `WAP_OFS_CTRL:    st_nxt.rdata = {23'h000000, st_r.opt,
                                      st_r.action_on, st_r.roll,
                                      st_r.trig, st_r.mode};
                `WAP_OFS_COUNT:   st_nxt.rdata = {14'h0000, st_r.cnt_inf,
                                      st_r.cnt};
                `WAP_OFS_RECLEN:  st_nxt.rdata = {5'h00, st_r.reclen};
                `WAP_OFS_ENVDIV:  st_nxt.rdata = {16'h0000, st_r.env_div};
                `WAP_OFS_DISPLEN: st_nxt.rdata = {5'h00, st_r.disp_len};
                `WAP_OFS_STATUS:  st_nxt.rdata = {24'h000000, st_r.pend,
                                      !avg, st_r.mode == MODE_ENVELOPE,
                                      st_r.fsm == ST_RUN, st_r.err};
                `WAP_OFS_ACQN:    st_nxt.rdata = {15'h0000, st_r.acq_n};
                `WAP_OFS_EXPK:    st_nxt.rdata = {28'h0000000, st_r.exp_k};
                default:          st_nxt.rdata = 32'h00000000;
            endcase
        end

        // Register writes
        if (wr_hit) begin
            case (i_addr)
                `WAP_OFS_CTRL: begin
                    st_nxt.trig      = wap_trig_t'(i_wdata[4:2]);
                    st_nxt.roll      = i_wdata[5];
                    st_nxt.action_on = i_wdata[6];
                    st_nxt.opt       = i_wdata[8:7];
                    if (wap_mode_t'(i_wdata[1:0]) == MODE_AVERAGE) begin
                        if (i_wdata[5] ||
                            i_wdata[4:2] == TRIG_SINGLE ||
                            i_wdata[4:2] == TRIG_N_SINGLE ||
                            i_wdata[4:2] == TRIG_ON_START) begin
                            st_nxt.err[`WAP_ERR_MODE] = 1'b1;
                        end else begin
                            st_nxt.mode = MODE_AVERAGE;
                            // Clamp length to the averaging cap
                            if (st_r.reclen > len_cap(i_wdata[8:7], 1'b1)) begin
                                st_nxt.reclen = len_cap(i_wdata[8:7], 1'b1);
                            end
                            // A count of one or not a power of two falls back to infinite
                            if (!cnt_ok(st_r.cnt, 1'b1)) begin
                                st_nxt.cnt_inf = 1'b1;
                            end
                        end
                    end else if (i_wdata[1:0] != 2'h3) begin
                        st_nxt.mode = wap_mode_t'(i_wdata[1:0]);
                    end else begin
                        st_nxt.err[`WAP_ERR_MODE] = 1'b1;
                    end
                end
                `WAP_OFS_COUNT: begin
                    if (single_like && !st_r.action_on) begin
                        st_nxt.err[`WAP_ERR_COUNT] = 1'b1;
                    end else if (!i_wdata[`WAP_CNT_INF] &&
                                 !cnt_ok(i_wdata[16:0], avg)) begin
                        st_nxt.err[`WAP_ERR_COUNT] = 1'b1;
                    end else if (st_r.fsm == ST_RUN) begin
                        st_nxt.pend     = 1'b1;
                        st_nxt.pend_inf = i_wdata[`WAP_CNT_INF];
                        st_nxt.pend_cnt = i_wdata[16:0];
                    end else begin
                        st_nxt.cnt_inf  = i_wdata[`WAP_CNT_INF];
                        st_nxt.cnt      = i_wdata[16:0];
                    end
                end
                `WAP_OFS_RECLEN: begin
                    if (len_ok(i_wdata[26:0], st_r.opt, avg,
                               st_r.trig, st_r.roll)) begin
                        st_nxt.reclen = i_wdata[26:0];
                    end else begin
                        st_nxt.err[`WAP_ERR_LEN] = 1'b1;
                    end
                end
                `WAP_OFS_ENVDIV: begin
                    if (i_wdata[15:0] != 16'h0000) begin
                        st_nxt.env_div = i_wdata[15:0];
                    end
                end
                `WAP_OFS_DISPLEN: st_nxt.disp_len = i_wdata[26:0];
                `WAP_OFS_EXPK: begin
                    // Attenuation constant 2..256 as a shift of 1..8
                    if (i_wdata[3:0] >= 4'h1 && i_wdata[3:0] <= 4'h8) begin
                        st_nxt.exp_k = i_wdata[3:0];
                    end else begin
                        st_nxt.err[`WAP_ERR_EXPK] = 1'b1;
                    end
                end
                `WAP_OFS_STATUS: begin
                    // Write one to clear; no set shares a STATUS write
                    st_nxt.err = st_r.err & ~i_wdata[3:0];
                end
                default: ;
            endcase
        end

        // Start and stop commands; stop wins when both are set
        if (wr_hit && i_addr == `WAP_OFS_CMD) begin
            if (i_wdata[`WAP_CMD_STOP]) begin
                st_nxt.fsm = ST_IDLE;
            end else if (i_wdata[`WAP_CMD_START] && st_r.fsm == ST_IDLE) begin
                // Restart clears the running average state
                st_nxt.fsm     = ST_RUN;
                st_nxt.acq_n   = 17'h00000;
                st_nxt.base    = 32'h00000000;
                st_nxt.env_cnt = 16'h0000;
                st_nxt.env_pt  = 27'h0000000;
            end
        end

        // Sample path, active only while running
        if (st_r.fsm == ST_RUN && i_smp_valid) begin
            st_nxt.pwr_valid  = 1'b1;
            st_nxt.pwr_data   = i_smp_data;
            st_nxt.meas_valid = (i_smp_idx < st_r.disp_len);
            case (st_r.mode)
                MODE_ENVELOPE: begin
                    st_nxt.env_max = new_max;
                    st_nxt.env_min = new_min;
                    if (st_r.env_cnt + 16'h0001 == st_r.env_div) begin
                        st_nxt.mem_we    = 1'b1;
                        st_nxt.mem_addr  = st_r.base + 32'(st_r.env_pt);
                        st_nxt.mem_wdata = {new_max, new_min};
                        st_nxt.env_cnt   = 16'h0000;
                        st_nxt.env_pt    = st_r.env_pt + 27'h0000001;
                    end else begin
                        st_nxt.env_cnt = st_r.env_cnt + 16'h0001;
                    end
                end
                MODE_AVERAGE: begin
                    // One record at offset zero, same index each trigger
                    st_nxt.mem_we   = 1'b1;
                    st_nxt.mem_addr = 32'(i_smp_idx);
                    if (i_smp_pulse || st_r.acq_n == 17'h00000) begin
                        st_nxt.mem_wdata = smp_ext;
                    end else if (st_r.cnt_inf) begin
                        acc = prev + ((smp_ext - prev) >>> st_r.exp_k);
                        st_nxt.mem_wdata = acc;
                    end else begin
                        // Running sum, divided on the final acquisition
                        acc = prev + smp_ext;
                        if (st_r.acq_n + 17'h00001 == st_r.cnt) begin
                            acc = acc >>> log2p(st_r.cnt);
                        end
                        st_nxt.mem_wdata = acc;
                    end
                end
                default: begin
                    st_nxt.mem_we    = 1'b1;
                    st_nxt.mem_addr  = st_r.base + 32'(i_smp_idx);
                    st_nxt.mem_wdata = smp_ext;
                end
            endcase
        end

        // End of one triggered record
        if (rec_end) begin
            st_nxt.acq_n   = st_r.acq_n + 17'h00001;
            st_nxt.env_cnt = 16'h0000;
            st_nxt.env_pt  = 27'h0000000;
            if (!avg) begin
                st_nxt.base = st_r.base + 32'(st_r.reclen);
            end
            if (stop_now) begin
                st_nxt.fsm = ST_IDLE;
            end
        end

        // A held count takes effect once acquisition has stopped
        if (st_r.fsm == ST_IDLE && st_r.pend) begin
            st_nxt.pend    = 1'b0;
            st_nxt.cnt_inf = st_r.pend_inf;
            st_nxt.cnt     = st_r.pend_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register stage, frozen while the clock enable is low unless reset is high
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_r           <= '0; // Idle, normal mode, auto trigger
            st_r.cnt_inf   <= 1'b1;
            st_r.cnt       <= 17'h00001;
            st_r.exp_k     <= `WAP_RST_EXPK;
            st_r.reclen    <= `WAP_RST_RECLEN;
            st_r.disp_len  <= `WAP_RST_DISPLEN;
            st_r.env_div   <= `WAP_RST_ENVDIV;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign o_rdata        = st_r.rdata;
    assign o_mem_we       = st_r.mem_we;
    assign o_mem_addr     = st_r.mem_addr;
    assign o_mem_wdata    = st_r.mem_wdata;
    assign o_meas_valid   = st_r.meas_valid;
    assign o_meas_invalid = (st_r.mode == MODE_ENVELOPE);
    assign o_hist_ok      = (st_r.mode != MODE_AVERAGE);
    assign o_pwr_valid    = st_r.pwr_valid;
    assign o_pwr_data     = st_r.pwr_data;
    assign o_running      = (st_r.fsm == ST_RUN);

endmodule : wap_core

// ===== verification/wap_chk_assertions.sv
`timescale 1ns/100ps
// Port-level checks of the acquisition processor
module wap_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_smp_valid,
    input wire logic [15:0] i_smp_data,
    input wire logic        i_smp_pulse,
    input wire logic        o_mem_we,
    input wire logic [31:0] o_mem_wdata,
    input wire logic        o_meas_invalid,
    input wire logic        o_hist_ok,
    input wire logic        o_pwr_valid,
    input wire logic [15:0] o_pwr_data,
    input wire logic        o_running
);
    logic take;
    logic ctl_wr;
    logic no_avg;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////
    // Decode shared by the checks; mode itself is seen only
    // through the envelope and history flags
    assign take   = i_smp_valid && i_ce && o_running;
    assign ctl_wr = i_wr && i_ce && (i_addr == 8'h00);
    assign no_avg = i_wdata[5] || (i_wdata[4:2] inside {3'h3, 3'h4, 3'h5});

    norm_raw_a: assert property (
        take && o_hist_ok && !o_meas_invalid
        |=> o_mem_we && o_mem_wdata[15:0] == $past(i_smp_data))
        else $error("normal sample not stored raw");
    env_pair_a: assert property (
        o_mem_we && o_meas_invalid
        |-> $signed(o_mem_wdata[31:16]) >= $signed(o_mem_wdata[15:0]))
        else $error("envelope pair out of order");
    env_flag_a: assert property (
        ctl_wr && i_wdata[1:0] == 2'b01 |=> ##[0:1] o_meas_invalid)
        else $error("envelope entry without invalid flag");
    avg_hist_a: assert property (
        ctl_wr && i_wdata[1:0] == 2'b10 && !no_avg |=> ##[0:1] !o_hist_ok)
        else $error("history still offered in average");
    avg_refuse_a: assert property (
        ctl_wr && i_wdata[1:0] == 2'b10 && no_avg && o_hist_ok
        |=> o_hist_ok [*2])
        else $error("average entered against restriction");
    pulse_raw_a: assert property (
        take && i_smp_pulse && !o_hist_ok
        |=> o_mem_we && o_mem_wdata[15:0] == $past(i_smp_data))
        else $error("pulse channel sample was averaged");
    pwr_copy_a: assert property (
        take |=> o_pwr_valid && o_pwr_data == $past(i_smp_data))
        else $error("power path lost raw sample");
    run_stop_a: assert property (
        i_wr && i_ce && i_addr == 8'h04 && i_wdata[1] |=> !o_running)
        else $error("stop did not halt acquisition");

    // Main scenarios reached
    cover property (take && o_meas_invalid);
    cover property (take && !o_hist_ok && !i_smp_pulse);
    cover property (take && !o_hist_ok && i_smp_pulse);
endmodule : wap_chk

bind wap_core wap_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data),
    .i_smp_pulse(i_smp_pulse), .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata), .o_meas_invalid(o_meas_invalid),
    .o_hist_ok(o_hist_ok), .o_pwr_valid(o_pwr_valid),
    .o_pwr_data(o_pwr_data), .o_running(o_running)
);

// ===== verification/wap_dig_model.sv
`timescale 1ns/100ps
// Digitizer and acquisition memory stand-in
module wap_dig_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_mem_we,
    input  wire logic [31:0] i_mem_addr,
    input  wire logic [31:0] i_mem_wdata,
    output logic             o_valid,
    output logic      [15:0] o_data,
    output logic      [26:0] o_idx,
    output logic             o_last,
    output logic             o_pulse,
    output logic      [31:0] o_prev
);
    logic [31:0] mem [16];
    // Stale pattern at power-up so a missed restart cannot hide
    initial begin
        foreach (mem[j]) mem[j] = 32'h5A5A5A5A;
        o_valid = 1'b0;
        o_data  = 16'h0;
        o_idx   = 27'h0;
        o_last  = 1'b0;
        o_pulse = 1'b0;
    end
    // Keyed by low offset bits; record bases leave them clear
    always @(posedge i_ref_clk) begin
        if (i_mem_we) mem[i_mem_addr[3:0]] <= i_mem_wdata;
    end
    assign o_prev = mem[o_idx[3:0]];
    // One sample after g idle cycles; idle lines show inverted data
    task automatic send(input logic [15:0] d, input logic [26:0] x,
                        input logic l, input logic p, input int g);
        repeat (g) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        o_valid <= 1'b1;
        o_data  <= d;
        o_idx   <= x;
        o_last  <= l;
        o_pulse <= p;
        @(posedge i_ref_clk);
        o_valid <= 1'b0;
        o_data  <= ~d;
        o_idx   <= ~x;
        o_last  <= 1'b0;
        o_pulse <= 1'b0;
    endtask : send
endmodule : wap_dig_model

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
    import wap_pkg::*;
    logic        clk = 1'b0;
    logic        rst, ce, wr, rd, sv, sl, sp, we, mv, mi, ho, pv, run;
    logic [7:0]  addr;
    logic [15:0] sd, pdat;
    logic [26:0] si;
    logic [31:0] wdata, rdata, pd, ma, mw;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #5 clk = ~clk;
    // Block under test and its digitizer stand-in
    wap_core DUT (
        .i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_smp_valid(sv), .i_smp_data(sd), .i_smp_idx(si),
        .i_smp_last(sl), .i_smp_pulse(sp), .i_prev_data(pd),
        .o_mem_we(we), .o_mem_addr(ma), .o_mem_wdata(mw),
        .o_meas_valid(mv), .o_meas_invalid(mi), .o_hist_ok(ho),
        .o_pwr_valid(pv), .o_pwr_data(pdat), .o_running(run));
    wap_dig_model dig (
        .i_ref_clk(clk), .i_mem_we(we), .i_mem_addr(ma),
        .i_mem_wdata(mw), .o_valid(sv), .o_data(sd), .o_idx(si),
        .o_last(sl), .o_pulse(sp), .o_prev(pd));
    ////////////////////////////////////////////////////////////
    // Compare helpers and bus cycles
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic chkb(input string n, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", n, e, s);
        end
    endtask : chkb
    // Ends a settled moment after the edge that takes the write
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wrr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), e, rdata & m);
    endtask : rdc
    task automatic sm(input logic [15:0] d, input logic [26:0] x,
                      input logic l, input logic p);
        dig.send(d, x, l, p, 0);
        #1;
    endtask : sm
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rdc(8'h08, 32'h00020000, 32'h00020000);
        rdc(8'h0C, 32'hFFFFFFFF, 32'h000186A0);
        rdc(8'h18, 32'h000000FF, 32'h00000040);
        rdc(8'hFC, 32'hFFFFFFFF, 32'h00000000);
        ce <= 1'b0;
        wrr(8'h14, 32'h5);
        ce <= 1'b1;
        rdc(8'h14, 32'hFFFFFFFF, 32'h000186A0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_normal;
        wrr(8'h04, 32'h1);
        sm(16'h1234, 27'd3, 1'b0, 1'b0);
        chk("mem addr", 32'h3, ma);
        chk("mem data", 32'h1234, mw);
        chk("pwr data", 32'h1234, {16'h0, pdat});
        chkb("meas valid", 1'b1, mv);
        // Slow delivery at the display length boundary, closing a record
        dig.send(16'h8001, 27'd100000, 1'b1, 1'b0, 3);
        #1;
        chk("mem data", 32'h8001, {16'h0, mw[15:0]});
        chkb("meas valid", 1'b0, mv);
        chkb("running", 1'b1, run);
        wrr(8'h08, 32'h4);
        rdc(8'h18, 32'h80, 32'h80);
        rdc(8'h08, 32'h20000, 32'h20000);
        wrr(8'h04, 32'h2);
        chkb("running", 1'b0, run);
        repeat (2) @(posedge clk);
        rdc(8'h08, 32'h3FFFF, 32'h4);
        wrr(8'h08, 32'h20000);
        $display("test normal done");
    endtask : t_normal
    task automatic t_limits;
        logic [31:0] v [4];
        v = '{32'h22, 32'h0E, 32'h12, 32'h16};
        wrr(8'h0C, 32'd99999);
        rdc(8'h18, 32'h4, 32'h4);
        wrr(8'h18, 32'hF);
        wrr(8'h0C, 32'd5000000);
        rdc(8'h18, 32'h4, 32'h4);
        rdc(8'h0C, 32'hFFFFFFFF, 32'd100000);
        wrr(8'h18, 32'hF);
        wrr(8'h00, 32'h20);
        wrr(8'h0C, 32'd5000000);
        rdc(8'h18, 32'h4, 32'h0);
        wrr(8'h00, 32'h0C);
        wrr(8'h08, 32'h8);
        rdc(8'h18, 32'h2, 32'h2);
        wrr(8'h00, 32'h4C);
        wrr(8'h08, 32'h8);
        rdc(8'h08, 32'h3FFFF, 32'h8);
        wrr(8'h08, 32'h20000);
        // Roll and each single-style trigger must keep average out
        foreach (v[j]) begin
            wrr(8'h18, 32'hF);
            wrr(8'h00, v[j]);
            rdc(8'h18, 32'h41, 32'h41);
        end
        wrr(8'h00, 32'h0);
        $display("test limits done");
    endtask : t_limits
    task automatic t_env;
        wrr(8'h00, 32'h1);
        wrr(8'h04, 32'h1);
        chkb("meas invalid", 1'b1, mi);
        sm(16'h0005, 27'd0, 1'b0, 1'b0);
        chkb("mem we", 1'b0, we);
        sm(16'hFFFD, 27'd1, 1'b0, 1'b0);
        chk("env pair", 32'h0005FFFD, mw);
        wrr(8'h04, 32'h2);
        $display("test envelope done");
    endtask : t_env
    task automatic t_avg;
        wrr(8'h00, 32'h2);
        wrr(8'h04, 32'h1);
        chkb("hist ok", 1'b0, ho);
        sm(16'd100, 27'd5, 1'b1, 1'b0);
        chk("avg data", 32'd100, mw);
        sm(16'd200, 27'd5, 1'b1, 1'b0);
        chk("avg data", 32'd150, mw);
        sm(16'd7, 27'd5, 1'b0, 1'b1);
        chk("pulse data", 32'd7, mw);
        wrr(8'h04, 32'h2);
        wrr(8'h04, 32'h1);
        sm(16'd40, 27'd5, 1'b1, 1'b0);
        chk("avg data", 32'd40, mw);
        wrr(8'h04, 32'h2);
        wrr(8'h18, 32'hF);
        wrr(8'h08, 32'h3);
        wrr(8'h20, 32'h9);
        rdc(8'h18, 32'hA, 32'hA);
        wrr(8'h08, 32'h2);
        wrr(8'h04, 32'h1);
        sm(16'd10, 27'd5, 1'b1, 1'b0);
        sm(16'd20, 27'd5, 1'b1, 1'b0);
        chk("lin avg", 32'd15, mw);
        repeat (2) @(posedge clk);
        #1;
        chkb("running", 1'b0, run);
        rdc(8'h1C, 32'hFFFFFFFF, 32'h2);
        $display("test average done");
    endtask : t_avg
    // Cut a hang short; the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // Reset for sixteen cycles, then run the scenarios in turn
    initial begin
        rst   = 1'b1;
        ce    = 1'b1;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 8'h00;
        wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_normal();
        t_limits();
        t_env();
        t_avg();
        report_and_stop();
    end
endmodule : tb
